// file: mab_alu_core.sv
// Execution datapath for add, and, bit set/clear and bit test-skip
//
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`include "mab_defs.svh"

module mab_alu_core
(
    input  wire logic        CLK,
    input  wire logic        RESET,
    input  wire logic [9:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [9:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    input  wire logic [7:0]  PORT_PIN,
    output logic [7:0]       PORT_LATCH,
    output logic             PRESCALE_CLR,
    output logic             SKIP_NEXT
);

    mab_pkg::mab_state_t s_q;
    mab_pkg::mab_state_t s_d;

    logic [31:0]      cmd_w;
    mab_pkg::mab_op_t op_w;
    logic [7:0]       lit_w;
    logic [6:0]       fa_w;
    logic [2:0]       bsel_w;
    logic             dst_w;
    logic [7:0]       src_w;
    logic [7:0]       opnd_w;
    logic [8:0]       sum_w;
    logic [4:0]       half_w;
    logic [7:0]       and_w;
    logic [7:0]       mask_w;
    logic             do_wr;
    logic             issue;
    logic             run;
    logic             tbit_w;

    // Byte-lane merge of a bus write into an old word
    function automatic logic [31:0] lane_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  strb
    );
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                r[i*8 +: 8] = new_v[i*8 +: 8];
        end
        return r;
    endfunction : lane_merge

    // ****************************************************************
    // Operand decode and arithmetic
    // ****************************************************************

    // A write lands only with both halves held and no answer pending
    assign do_wr  = s_q.aw_full && s_q.w_full && !s_q.bvalid;
    assign issue  = do_wr && (s_q.aw_addr == `MAB_OFF_CMD);
    assign run    = issue && !s_q.skip;
    assign cmd_w  = lane_merge(s_q.cmd, s_q.w_data, s_q.w_strb);
    assign op_w   = mab_pkg::mab_op_t'(cmd_w[`MAB_CMD_OP_LSB +: 3]);
    assign lit_w  = cmd_w[`MAB_CMD_LIT_LSB +: 8];
    assign fa_w   = cmd_w[`MAB_CMD_FA_LSB +: 7];
    assign bsel_w = cmd_w[`MAB_CMD_BIT_LSB +: 3];
    assign dst_w  = cmd_w[`MAB_CMD_DST_BIT];

    // The port reads its pins, not the latch, so a modify keeps input levels
    assign src_w  = (fa_w == `MAB_PORT_ADDR) ? s_q.sync2 : s_q.file[fa_w];
    assign opnd_w = (op_w == mab_pkg::OP_ADD_IMM || op_w == mab_pkg::OP_AND_IMM)
                    ? lit_w : src_w;
    // Nine-bit sum keeps the carry out of bit 7, five-bit the nibble carry
    assign sum_w  = {1'b0, s_q.acc} + {1'b0, opnd_w};
    assign half_w = {1'b0, s_q.acc[3:0]} + {1'b0, opnd_w[3:0]};
    assign and_w  = s_q.acc & opnd_w;
    assign mask_w = 8'h01 << bsel_w;
    assign tbit_w = src_w[bsel_w];

    // ****************************************************************
    // Next state
    // ****************************************************************

    // Bus slave, synchroniser and instruction execution in one pass
    always_comb
    begin
        logic       fwr;
        logic [7:0] fval;
        logic [7:0] res;
        fwr  = 1'b0;
        fval = 8'h00;
        res  = 8'h00;
        s_d  = s_q;
        s_d.pclr  = 1'b0;
        s_d.sync1 = PORT_PIN;
        s_d.sync2 = s_q.sync1;
        if (S_AXI_AWVALID && s_q.aw_rdy)
        begin
            s_d.aw_full = 1'b1;
            s_d.aw_addr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && s_q.w_rdy)
        begin
            s_d.w_full = 1'b1;
            s_d.w_data = S_AXI_WDATA;
            s_d.w_strb = S_AXI_WSTRB;
        end
        if (S_AXI_BREADY && s_q.bvalid)
            s_d.bvalid = 1'b0;
        if (do_wr)
        begin
            s_d.bvalid  = 1'b1;
            s_d.bresp   = `MAB_RESP_OKAY;
            s_d.aw_full = 1'b0;
            s_d.w_full  = 1'b0;
            if (issue)
            begin
                s_d.cmd = cmd_w;
                if (s_q.skip)
                    s_d.skip = 1'b0;
                else
                begin
                    case (op_w)
                        mab_pkg::OP_ADD_IMM:
                        begin
                            s_d.acc = sum_w[7:0];
                            s_d.c   = sum_w[8];
                            s_d.dc  = half_w[4];
                            s_d.z   = (sum_w[7:0] == 8'h00);
                        end
                        mab_pkg::OP_ADD_FILE:
                        begin
                            res     = sum_w[7:0];
                            s_d.c   = sum_w[8];
                            s_d.dc  = half_w[4];
                            s_d.z   = (sum_w[7:0] == 8'h00);
                        end
                        mab_pkg::OP_AND_IMM:
                        begin
                            s_d.acc = and_w;
                            s_d.z   = (and_w == 8'h00);
                        end
                        mab_pkg::OP_AND_FILE:
                        begin
                            res     = and_w;
                            s_d.z   = (and_w == 8'h00);
                        end
                        mab_pkg::OP_BIT_CLR:
                        begin
                            fwr  = 1'b1;
                            fval = src_w & ~mask_w;
                        end
                        mab_pkg::OP_BIT_SET:
                        begin
                            fwr  = 1'b1;
                            fval = src_w | mask_w;
                        end
                        mab_pkg::OP_SKIP_SET:
                            s_d.skip = tbit_w;
                        mab_pkg::OP_SKIP_CLR:
                            s_d.skip = !tbit_w;
                        default:
                            s_d.skip = 1'b0;
                    endcase
                    // Two-operand file ops pick their destination
                    if (op_w == mab_pkg::OP_ADD_FILE
                        || op_w == mab_pkg::OP_AND_FILE)
                    begin
                        if (dst_w)
                        begin
                            fwr  = 1'b1;
                            fval = res;
                        end
                        else
                            s_d.acc = res;
                    end
                    if (fwr)
                    begin
                        s_d.file[fa_w] = fval;
                        if (fa_w == `MAB_TMR_ADDR && s_q.psa)
                            s_d.pclr = 1'b1;
                    end
                end
            end
            else if (s_q.aw_addr == `MAB_OFF_ACC)
            begin
                if (s_q.w_strb[0])
                    s_d.acc = s_q.w_data[7:0];
            end
            else if (s_q.aw_addr == `MAB_OFF_STATUS)
            begin
                if (s_q.w_strb[0])
                begin
                    s_d.c   = s_q.w_data[`MAB_ST_C];
                    s_d.dc  = s_q.w_data[`MAB_ST_DC];
                    s_d.z   = s_q.w_data[`MAB_ST_Z];
                    s_d.psa = s_q.w_data[`MAB_ST_PSA];
                end
            end
            else if (s_q.aw_addr[9] && s_q.aw_addr[1:0] == 2'h0)
            begin
                if (s_q.w_strb[0])
                    s_d.file[s_q.aw_addr[8:2]] = s_q.w_data[7:0];
            end
            else
                s_d.bresp = `MAB_RESP_SLVERR;
        end
        s_d.aw_rdy = !s_d.aw_full;
        s_d.w_rdy  = !s_d.w_full;
        // Read channel: one outstanding read, answered the next cycle
        if (S_AXI_RREADY && s_q.rvalid)
        begin
            s_d.rvalid = 1'b0;
            s_d.ar_rdy = 1'b1;
        end
        if (S_AXI_ARVALID && s_q.ar_rdy)
        begin
            s_d.rvalid = 1'b1;
            s_d.ar_rdy = 1'b0;
            s_d.rresp  = `MAB_RESP_OKAY;
            s_d.rdata  = 32'h0000_0000;
            if (S_AXI_ARADDR == `MAB_OFF_CMD)
                s_d.rdata = s_q.cmd;
            else if (S_AXI_ARADDR == `MAB_OFF_ACC)
                s_d.rdata[7:0] = s_q.acc;
            else if (S_AXI_ARADDR == `MAB_OFF_STATUS)
                s_d.rdata[4:0] = {s_q.psa, s_q.skip, s_q.z, s_q.dc, s_q.c};
            else if (S_AXI_ARADDR[9] && S_AXI_ARADDR[1:0] == 2'h0)
                s_d.rdata[7:0] = (S_AXI_ARADDR[8:2] == `MAB_PORT_ADDR)
                                 ? s_q.sync2 : s_q.file[S_AXI_ARADDR[8:2]];
            else
                s_d.rresp = `MAB_RESP_SLVERR;
        end
    end

    // ****************************************************************
    // State register and outputs
    // ****************************************************************

    // Synchronous reset to constants only
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            s_q        <= '0;
            s_q.acc    <= `MAB_ACC_RST;
            s_q.cmd    <= `MAB_CMD_RST;
            s_q.aw_rdy <= 1'b1;
            s_q.w_rdy  <= 1'b1;
            s_q.ar_rdy <= 1'b1;
        end
        else
            s_q <= s_d;
    end

    assign S_AXI_AWREADY = s_q.aw_rdy;
    assign S_AXI_WREADY  = s_q.w_rdy;
    assign S_AXI_BVALID  = s_q.bvalid;
    assign S_AXI_BRESP   = s_q.bresp;
    assign S_AXI_ARREADY = s_q.ar_rdy;
    assign S_AXI_RVALID  = s_q.rvalid;
    assign S_AXI_RDATA   = s_q.rdata;
    assign S_AXI_RRESP   = s_q.rresp;
    assign PORT_LATCH    = s_q.file[`MAB_PORT_ADDR];
    assign PRESCALE_CLR  = s_q.pclr;
    assign SKIP_NEXT     = s_q.skip;

    // ****************************************************************
    // Checks
    // ****************************************************************

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    sequence add_issue;
        run && (op_w == mab_pkg::OP_ADD_IMM);
    endsequence

    // A command issued while a skip is pending is stored but must not execute, only clear the skip
    sequence skip_armed;
        issue && s_q.skip;
    endsequence

    chk_add_imm_sum: assert property (add_issue |=> s_q.acc == $past(sum_w[7:0]))
        else $error("add immediate sum wrong");
    chk_add_carry_flags: assert property (run && (op_w == mab_pkg::OP_ADD_FILE)
        |=> s_q.c == $past(sum_w[8]) && s_q.dc == $past(half_w[4]))
        else $error("add file flags wrong");
    chk_dest_to_file: assert property (run && dst_w
        && (op_w == mab_pkg::OP_AND_FILE) |=> $stable(s_q.acc))
        else $error("file destination altered accumulator");
    chk_and_imm_carry: assert property (run && (op_w == mab_pkg::OP_AND_IMM)
        |=> $stable(s_q.c) && s_q.z == (s_q.acc == 8'h00))
        else $error("and immediate flags wrong");
    chk_bit_clear: assert property (run && (op_w == mab_pkg::OP_BIT_CLR)
        |=> s_q.file[$past(fa_w)][$past(bsel_w)] == 1'b0 && $stable(s_q.z))
        else $error("bit clear failed");
    chk_skip_then_nop: assert property (skip_armed
        |=> !s_q.skip && $stable(s_q.acc) && $stable(s_q.z))
        else $error("skipped instruction executed");
    chk_skip_clear_arm: assert property (run
        && (op_w == mab_pkg::OP_SKIP_CLR) |=> s_q.skip == !$past(tbit_w))
        else $error("skip if clear wrong");
    chk_test_no_flags: assert property (run && (op_w == mab_pkg::OP_SKIP_SET
        || op_w == mab_pkg::OP_SKIP_CLR) |=> $stable(s_q.c) && $stable(s_q.z))
        else $error("bit test changed flags");
    chk_prescale_clear: assert property (PRESCALE_CLR
        |-> $past(run) && $past(fa_w) == `MAB_TMR_ADDR && $past(s_q.psa))
        else $error("prescaler cleared without cause");

endmodule : mab_alu_core

// file: mab_defs.svh
// Constants for the bit and arithmetic execution datapath
`ifndef MAB_DEFS_SVH
`define MAB_DEFS_SVH

// Register byte offsets on the AXI4-Lite slave
`define MAB_OFF_CMD      10'h000
`define MAB_OFF_ACC      10'h004
`define MAB_OFF_STATUS   10'h008
`define MAB_OFF_FILE     10'h200

// Command word fields
`define MAB_CMD_LIT_LSB  0
`define MAB_CMD_FA_LSB   8
`define MAB_CMD_BIT_LSB  15
`define MAB_CMD_DST_BIT  18
`define MAB_CMD_OP_LSB   20

// Status word fields
`define MAB_ST_C         0
`define MAB_ST_DC        1
`define MAB_ST_Z         2
`define MAB_ST_SKIP      3
`define MAB_ST_PSA       4

// File addresses with side effects
`define MAB_PORT_ADDR    7'h06
`define MAB_TMR_ADDR     7'h01

// Reset values
`define MAB_ACC_RST      8'h00
`define MAB_CMD_RST      32'h0000_0000

// Bus response codes
`define MAB_RESP_OKAY    2'h0
`define MAB_RESP_SLVERR  2'h2

`endif

// file: mab_pkg.sv
// Types for the bit and arithmetic execution datapath
package mab_pkg;

    // Operation codes, Gray order along the usual issue path
    typedef enum logic [2:0] {
        OP_ADD_IMM  = 3'h0,
        OP_ADD_FILE = 3'h1,
        OP_AND_IMM  = 3'h3,
        OP_AND_FILE = 3'h2,
        OP_BIT_CLR  = 3'h6,
        OP_BIT_SET  = 3'h7,
        OP_SKIP_SET = 3'h5,
        OP_SKIP_CLR = 3'h4
    } mab_op_t;

    // Whole state of the core
    typedef struct packed {
        logic [127:0][7:0] file;
        logic [7:0]        acc;
        logic              c;
        logic              dc;
        logic              z;
        logic              skip;
        logic              psa;
        logic              pclr;
        logic [31:0]       cmd;
        logic [7:0]        sync1;
        logic [7:0]        sync2;
        logic              aw_full;
        logic              aw_rdy;
        logic [9:0]        aw_addr;
        logic              w_full;
        logic              w_rdy;
        logic [31:0]       w_data;
        logic [3:0]        w_strb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              ar_rdy;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
    } mab_state_t;

endpackage : mab_pkg

// file: tb_mcu_alu_bit_and_arith_ops.sv
// Self-checking bench for the bit and arithmetic execution datapath
`timescale 1ns/1ns
`include "mab_defs.svh"

module tb_mcu_alu_bit_and_arith_ops;
    // ****************************************************************
    // Stimulus, design outputs and reference model state
    // ****************************************************************
    logic        clk      = 1'b0;
    logic        reset    = 1'b1;
    logic [9:0]  awaddr   = 10'h000;
    logic [9:0]  araddr   = 10'h000;
    logic        awvalid  = 1'b0;
    logic        wvalid   = 1'b0;
    logic        bready   = 1'b0;
    logic        arvalid  = 1'b0;
    logic        rready   = 1'b0;
    logic [31:0] wdata    = 32'h0000_0000;
    logic [3:0]  wstrb    = 4'hF;
    logic [7:0]  port_pin = 8'h00;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        prescale_clr, skip_next;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [7:0]  port_latch;
    logic [7:0]  m_file [128];
    logic [7:0]  m_acc, pins_m;
    logic        m_c, m_dc, m_z, m_skip, m_psa;
    int          exp_pulses, pulses, fail_count, checks_done, cyc;

    mab_alu_core u_mab_alu_core (
        .CLK(clk), .RESET(reset),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .PORT_PIN(port_pin),
        .PORT_LATCH(port_latch), .PRESCALE_CLR(prescale_clr),
        .SKIP_NEXT(skip_next)
    );

    // Clock, pulse counter and hang guard
    always #5 clk = ~clk;
    always @(posedge clk)
    begin
        if (prescale_clr === 1'b1) pulses++; // Stuck high overcounts
        cyc++;
        if (cyc == 40000)
        begin
            fail_count++;
            finish_test();
        end
    end

    // ****************************************************************
    // Bus tasks and comparison
    // ****************************************************************
    task check(input logic [31:0] got, input logic [31:0] exp,
               input string what);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t %s got %h exp %h",
                     $time, what, got, exp);
        end
    endtask : check

    // Leading edge wait keeps a new request off the previous release
    task wr(input logic [9:0] a, input logic [31:0] d, input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done)
        begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1)
            begin
                done = 1'b1;
                bready <= 1'b0;
                check(32'(bresp), 32'(er), "bresp");
            end
        end
    endtask : wr

    task rd(input logic [9:0] a, output logic [31:0] d, input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done)
        begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1)
            begin
                done = 1'b1;
                d = rdata;
                rready <= 1'b0;
                check(32'(rresp), 32'(er), "rresp");
            end
        end
    endtask : rd

    // Accumulator, flags, one file register and the outputs against the model
    task cmp_state(input logic [6:0] fa);
        logic [31:0] v;
        rd(`MAB_OFF_ACC, v, `MAB_RESP_OKAY);
        check(v, {24'h0, m_acc}, "acc");
        rd(`MAB_OFF_STATUS, v, `MAB_RESP_OKAY);
        check(v, {27'h0, m_psa, m_skip, m_z, m_dc, m_c}, "flags");
        rd(10'h200 + {1'b0, fa, 2'b00}, v, `MAB_RESP_OKAY);
        check(v, {24'h0, (fa == `MAB_PORT_ADDR) ? pins_m : m_file[fa]},
              "file");
        check(32'(port_latch), {24'h0, m_file[6]}, "latch");
        check(32'(skip_next), 32'(m_skip), "skip");
        check(pulses, exp_pulses, "prescaler clear");
    endtask : cmp_state

    // ****************************************************************
    // Reference model of one issued instruction
    // ****************************************************************
    task exec(input logic [31:0] cmd);
        logic [7:0] k, src, a, res;
        logic [8:0] s;
        logic [4:0] h;
        logic [2:0] b;
        logic [6:0] fa;
        logic       wf, wa;
        mab_pkg::mab_op_t op;
        k = cmd[7:0];
        fa = cmd[14:8];
        b = cmd[17:15];
        op = mab_pkg::mab_op_t'(cmd[22:20]);
        src = (fa == `MAB_PORT_ADDR) ? pins_m : m_file[fa];
        a = (op == mab_pkg::OP_ADD_IMM || op == mab_pkg::OP_AND_IMM) ? k : src;
        s = {1'b0, m_acc} + {1'b0, a};
        h = {1'b0, m_acc[3:0]} + {1'b0, a[3:0]};
        res = 8'h00;
        wf = 1'b0;
        wa = 1'b0;
        if (m_skip) m_skip = 1'b0;
        else
        begin
            case (op)
                mab_pkg::OP_ADD_IMM, mab_pkg::OP_ADD_FILE:
                begin
                    res = s[7:0];
                    m_c = s[8];
                    m_dc = h[4];
                    m_z = (res == 8'h00);
                    wf = (op == mab_pkg::OP_ADD_FILE) && cmd[18];
                    wa = !wf;
                end
                mab_pkg::OP_AND_IMM, mab_pkg::OP_AND_FILE:
                begin
                    res = m_acc & a;
                    m_z = (res == 8'h00);
                    wf = (op == mab_pkg::OP_AND_FILE) && cmd[18];
                    wa = !wf;
                end
                mab_pkg::OP_BIT_CLR:
                begin
                    res = src & ~(8'h01 << b);
                    wf = 1'b1;
                end
                mab_pkg::OP_BIT_SET:
                begin
                    res = src | (8'h01 << b);
                    wf = 1'b1;
                end
                mab_pkg::OP_SKIP_SET: m_skip = src[b];
                default: m_skip = !src[b];
            endcase
            if (wa) m_acc = res;
            if (wf)
            begin
                m_file[fa] = res;
                if (fa == `MAB_TMR_ADDR && m_psa) exp_pulses++;
            end
        end
    endtask : exec

    task issue(input logic [31:0] cmd);
        wr(`MAB_OFF_CMD, cmd, `MAB_RESP_OKAY);
        exec(cmd);
        cmp_state(cmd[14:8]);
    endtask : issue

    task finish_test;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : finish_test

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        logic [31:0] v, r;
        logic [6:0]  fa;
        void'($urandom(32'h101E));
        foreach (m_file[i]) m_file[i] = 8'h00;
        {m_acc, pins_m, m_c, m_dc, m_z, m_skip, m_psa} = '0;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        cmp_state(7'h00);
        // Unmapped place is refused and reads as zero
        wr(10'h100, 32'hFFFF_FFFF, `MAB_RESP_SLVERR);
        rd(10'h100, v, `MAB_RESP_SLVERR);
        check(v, 32'h0000_0000, "unmapped");
        // Flags are all zero here, so only the prescaler bit moves
        wr(`MAB_OFF_STATUS, 32'h0000_0010, `MAB_RESP_OKAY);
        m_psa = 1'b1;
        for (int i = 0; i < 9; i++)
        begin
            fa = (i == 8) ? 7'h7F : 7'(i);
            v = $urandom;
            m_file[fa] = v[7:0];
            wr(10'h200 + {1'b0, fa, 2'b00}, {24'h0, v[7:0]}, `MAB_RESP_OKAY);
        end
        // Carry, nibble carry and zero all at once, then zero from AND
        wr(`MAB_OFF_ACC, 32'h0000_0001, `MAB_RESP_OKAY);
        m_acc = 8'h01;
        issue(32'h0000_00FF);
        issue(32'h0030_0000);
        for (int n = 0; n < 400; n++)
        begin
            if (n % 32 == 0)
            begin
                v = $urandom;
                port_pin <= v[7:0];
                pins_m = v[7:0];
                repeat (4) @(posedge clk); // Two-flop pin synchroniser
            end
            r = $urandom;
            fa = (r[3:0] == 4'hF) ? 7'h7F : {4'h0, r[6:4]};
            v = $urandom;
            issue({9'h0, v[10:8], 1'b0, v[11], v[14:12], fa, v[7:0]});
        end
        finish_test();
    end
endmodule : tb_mcu_alu_bit_and_arith_ops
